// File: hdl/cmsic_pkg.sv
package cmsic_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_DCMP_CNT   = 8'h04;
  localparam logic [7:0] ADDR_INT_VEC    = 8'h08;
  localparam logic [7:0] ADDR_FIFO_CTRL  = 8'h0c;
  localparam logic [7:0] ADDR_FIFO_PTR   = 8'h10;
  localparam logic [7:0] ADDR_INT_FLAGS  = 8'h14;
  localparam logic [7:0] ADDR_INT_ENA    = 8'h18;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int POS_IDLE_STOP  = 13;
  localparam int POS_ABORT      = 12;
  localparam int POS_REQ_LO     = 8;
  localparam int POS_CUR_LO     = 5;
  localparam int POS_CAPTURE    = 3;
  localparam int POS_WINDOW     = 0;
  localparam int POS_HIT_LO     = 8;
  localparam int POS_BUFCNT_LO  = 13;
  localparam int POS_WPTR_LO    = 8;
  localparam int POS_ERRST_LO   = 8;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] RST_MODE_REQ = 3'h4;
  localparam logic [7:0] FLAG_MASK    = 8'hef;

  // ---------------------------------------------------------------
  // interrupt codes
  // ---------------------------------------------------------------
  localparam logic [6:0] INTERRUPT_CODE_NONE  = 7'h40;
  localparam logic [6:0] INTERRUPT_CODE_ERR   = 7'h41;
  localparam logic [6:0] INTERRUPT_CODE_WAKE  = 7'h42;
  localparam logic [6:0] INTERRUPT_CODE_OVF   = 7'h43;
  localparam logic [6:0] INTERRUPT_CODE_FIFO  = 7'h44;
  localparam logic [4:0] DCMP_MAX    = 5'h11;
  localparam logic [5:0] BUF_MAX     = 6'h1f;

  // ---------------------------------------------------------------
  // bus idle detection
  // ---------------------------------------------------------------
  localparam logic [3:0] IDLE_BITS   = 4'hb;

  typedef enum logic [2:0] {
    CMSIC_NORMAL  = 3'b000,
    CMSIC_DISABLE = 3'b001,
    CMSIC_LOOP    = 3'b010,
    CMSIC_LISTEN  = 3'b011,
    CMSIC_CONFIG  = 3'b100,
    CMSIC_RSV5    = 3'b101,
    CMSIC_RSV6    = 3'b110,
    CMSIC_LALL    = 3'b111
  } cmsic_mode_e;

endpackage

// File: hdl/cmsic_top.sv
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - code 000 normal: pins given to the bus, send and receive.
// - listen-only 011: no error flags, no acknowledge, counters idle.
// - listen-only returns transmit pin to port use; receive pin stays input.
// - listen-all 111: ignore errors, accept all, keep partial data.
// - loopback 010: internal transmit feeds internal receive; pins released.
// - mode request decodes 000,001,010,011,100,111; 101 and 110 reserved.
// - read-only current mode reports mode in effect, same encoding.
// - abort bit signals all buffers; device clears it when aborts finish.
// - capture enable produces capture event on message receive.
// - data compare count 5 bits; codes above 10001 invalid.
// - interrupt code reports highest pending source, 1000000 when none.
// - codes 0..7 tx/rx buffers, 8..15 receive-only buffers.
// - buffer count select sizes message area; 111 reserved.
// - fifo start buffer selects first fifo buffer, 0..31.
// - read-only 6-bit fifo write and next-read pointers, 0..31.
// - read-only error state bits plus combined warning bit.
// - separate flags for seven interrupt sources.
// - enable bit per flag at same position gates the request.
// - mode change waits for 11 consecutive recessive bits.
// - fifo control and interrupt enable registers writable only in configuration mode.
module cmsic_top
  import cmsic_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bit_tick,
  input  wire logic        bus_receive_pin,
  input  wire logic        engine_tx,
  output logic             engine_rx,
  output logic             bus_transmit_pin,
  output logic             tx_pin_enable,
  output logic             rx_pin_enable,
  output logic             ack_err_enable,
  output logic             err_count_enable,
  output logic             ignore_errors,
  output logic             abort_all_tx,
  input  wire logic        aborts_done,
  input  wire logic        chip_idle,
  output logic             block_halt,
  input  wire logic        msg_received,
  output logic             capture_event,
  output logic             window_select,
  input  wire logic [4:0]  data_compare_count,
  input  wire logic [4:0]  filter_hit_number,
  input  wire logic [15:0] buf_pending,
  output logic [2:0]       buffer_count_select,
  output logic [4:0]       fifo_start_buffer,
  input  wire logic [5:0]  fifo_write_pointer,
  input  wire logic [5:0]  fifo_next_read,
  input  wire logic [5:0]  error_state,
  input  wire logic [7:0]  flag_set,
  output logic             irq
);

  // ---------------------------------------------------------------
  // pin synchroniser
  // ---------------------------------------------------------------
  logic       rx_meta;
  logic       rx_sync;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= bus_receive_pin;
      rx_sync <= rx_meta;
    end
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cmsic_mode_e mode_request;
  cmsic_mode_e current_mode;
  logic        idle_stop;
  logic        abort_bit;
  logic        rx_capture_enable;
  logic        window_sel;
  logic [2:0]  bufcnt;
  logic [4:0]  fstart;
  logic [7:0]  flags;
  logic [7:0]  enables;
  logic [3:0]  recessive_cnt;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire        wr_stb    = psel & penable & pwrite;
  wire        sel_ctrl  = (paddr == ADDR_MODE_CTRL);
  wire        sel_dcmp  = (paddr == ADDR_DCMP_CNT);
  wire        sel_vec   = (paddr == ADDR_INT_VEC);
  wire        sel_fctl  = (paddr == ADDR_FIFO_CTRL);
  wire        sel_fptr  = (paddr == ADDR_FIFO_PTR);
  wire        sel_flag  = (paddr == ADDR_INT_FLAGS);
  wire        sel_ena   = (paddr == ADDR_INT_ENA);
  wire        mapped    = sel_ctrl | sel_dcmp | sel_vec | sel_fctl |
                          sel_fptr | sel_flag | sel_ena;
  wire        in_config = (current_mode == CMSIC_CONFIG);
  wire        cfg_wr    = wr_stb & in_config;
  wire        bus_idle  = (recessive_cnt == IDLE_BITS);
  wire [2:0]  req_code  = pwdata[POS_REQ_LO +: 3];
  wire        req_valid = (req_code != CMSIC_RSV5) && (req_code != CMSIC_RSV6);
  wire        pending_change = (current_mode != mode_request);

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ---------------------------------------------------------------
  // recessive bit counter
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      recessive_cnt <= 4'h0;
    end else if (!rx_sync) begin
      recessive_cnt <= 4'h0;
    end else if (bit_tick && !bus_idle) begin
      recessive_cnt <= recessive_cnt + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // mode control register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_request      <= CMSIC_CONFIG;
      idle_stop         <= 1'b0;
      rx_capture_enable <= 1'b0;
      window_sel        <= 1'b0;
    end else if (wr_stb && sel_ctrl) begin
      if (req_valid) begin
        mode_request <= cmsic_mode_e'(req_code);
      end
      idle_stop         <= pwdata[POS_IDLE_STOP];
      rx_capture_enable <= pwdata[POS_CAPTURE];
      window_sel        <= pwdata[POS_WINDOW];
    end
  end

  // abort bit: set by software, cleared by hardware when done
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      abort_bit <= 1'b0;
    end else if (wr_stb && sel_ctrl && pwdata[POS_ABORT]) begin
      abort_bit <= 1'b1;
    end else if (abort_bit && aborts_done) begin
      abort_bit <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      current_mode <= CMSIC_CONFIG;
    end else if (pending_change && bus_idle) begin
      current_mode <= mode_request;
    end
  end

  // ---------------------------------------------------------------
  // fifo control and enables, config-locked
  // ---------------------------------------------------------------
  wire [7:0] ena_wdata = pwdata[7:0] & FLAG_MASK;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bufcnt  <= 3'h0;
      fstart  <= 5'h00;
      enables <= 8'h00;
    end else if (cfg_wr) begin
      if (sel_fctl) begin
        bufcnt <= pwdata[POS_BUFCNT_LO +: 3];
        fstart <= pwdata[4:0];
      end
      if (sel_ena) begin
        enables <= ena_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt flags: set wins over clear
  // ---------------------------------------------------------------
  wire [7:0] clr_mask = (wr_stb && sel_flag) ? ~pwdata[7:0] : 8'h00;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flags <= 8'h00;
    end else begin
      flags <= ((flags & ~clr_mask) | flag_set) & FLAG_MASK;
    end
  end

  assign irq = |(flags & enables);

  // ---------------------------------------------------------------
  // interrupt code priority
  // ---------------------------------------------------------------
  logic [6:0] interrupt_code;
  always_comb begin
    interrupt_code = INTERRUPT_CODE_NONE;
    if (flags[3]) begin
      interrupt_code = INTERRUPT_CODE_FIFO;
    end
    if (flags[2]) begin
      interrupt_code = INTERRUPT_CODE_OVF;
    end
    if (flags[6]) begin
      interrupt_code = INTERRUPT_CODE_WAKE;
    end
    if (flags[5]) begin
      interrupt_code = INTERRUPT_CODE_ERR;
    end
    for (int i = 15; i >= 0; i--) begin
      if (buf_pending[i]) begin
        interrupt_code = 7'(i);
      end
    end
  end

  // ---------------------------------------------------------------
  // mode-dependent outputs
  // ---------------------------------------------------------------
  wire m_normal = (current_mode == CMSIC_NORMAL);
  wire m_listen = (current_mode == CMSIC_LISTEN);
  wire m_lall   = (current_mode == CMSIC_LALL);
  wire m_loop   = (current_mode == CMSIC_LOOP);

  assign tx_pin_enable    = m_normal;
  assign rx_pin_enable    = m_normal | m_listen | m_lall;
  assign bus_transmit_pin = m_normal ? engine_tx : 1'b1;
  assign engine_rx        = m_loop ? engine_tx : rx_sync;
  assign ack_err_enable   = m_normal;
  assign err_count_enable = m_normal;
  assign ignore_errors    = m_lall;
  assign abort_all_tx     = abort_bit;
  assign block_halt       = idle_stop & chip_idle;
  assign capture_event    = rx_capture_enable & msg_received;
  assign window_select    = window_sel;
  assign buffer_count_select = bufcnt;
  assign fifo_start_buffer   = fstart;

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  wire [4:0] dcmp_safe = (data_compare_count > DCMP_MAX) ? 5'h00 : data_compare_count;
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0;
    if (sel_ctrl) begin
      rdata[POS_IDLE_STOP]      = idle_stop;
      rdata[POS_ABORT]          = abort_bit;
      rdata[POS_REQ_LO +: 3]    = mode_request;
      rdata[POS_CUR_LO +: 3]    = current_mode;
      rdata[POS_CAPTURE]        = rx_capture_enable;
      rdata[POS_WINDOW]         = window_sel;
    end else if (sel_dcmp) begin
      rdata[4:0] = dcmp_safe;
    end else if (sel_vec) begin
      rdata[POS_HIT_LO +: 5] = filter_hit_number;
      rdata[6:0]             = interrupt_code;
    end else if (sel_fctl) begin
      rdata[POS_BUFCNT_LO +: 3] = bufcnt;
      rdata[4:0]                = fstart;
    end else if (sel_fptr) begin
      rdata[POS_WPTR_LO +: 6] = fifo_write_pointer & BUF_MAX;
      rdata[5:0]              = fifo_next_read & BUF_MAX;
    end else if (sel_flag) begin
      rdata[POS_ERRST_LO +: 6] = error_state;
      rdata[7:0]               = flags;
    end else if (sel_ena) begin
      rdata[7:0] = enables;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_mode_waits_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (current_mode != $past(current_mode)) |-> $past(bus_idle))
    else $error("mode changed without idle bus");
  a_listen_passive: assert property (@(posedge sys_clk) disable iff (sys_rst)
    m_listen |-> (!ack_err_enable && !err_count_enable && !tx_pin_enable))
    else $error("listen mode not passive");
  a_loop_route: assert property (@(posedge sys_clk) disable iff (sys_rst)
    m_loop |-> (engine_rx == engine_tx && !rx_pin_enable))
    else $error("loopback routing wrong");
  a_abort_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (abort_bit && aborts_done && !(wr_stb && sel_ctrl)) |=> !abort_bit)
    else $error("abort bit not cleared");
  a_flag_set_wins: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (flag_set[0]) |=> flags[0])
    else $error("flag set lost");
  a_irq_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (flag_set[5] && enables[5] && !(wr_stb && sel_ena)) |=> irq)
    else $error("enabled flag gave no irq");
  a_cfg_lock: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!in_config) |=> $stable(enables) && $stable(bufcnt))
    else $error("config register changed outside config");
  a_capture_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (msg_received && !rx_capture_enable) |-> !capture_event)
    else $error("capture without enable");
  a_one_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wr_stb && sel_flag && pwdata[1] && flags[1]) |=> flags[1])
    else $error("write of one cleared flag");

  // ---------------------------------------------------------------
  // stepwise checks
  // ---------------------------------------------------------------
  sequence s_abort_write;
    wr_stb && sel_ctrl && pwdata[POS_ABORT];
  endsequence
  sequence s_idle_change;
    pending_change && bus_idle;
  endsequence
  sequence s_rsv_write;
    wr_stb && sel_ctrl && !req_valid;
  endsequence
  sequence s_zero_clear;
    wr_stb && sel_flag && !pwdata[0] && !flag_set[0];
  endsequence
  sequence s_ena_write;
    wr_stb && sel_ena && in_config;
  endsequence

  a_abort_set: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_abort_write |=> abort_all_tx)
    else $error("abort request not raised");
  a_mode_follows: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_idle_change |=> (current_mode == $past(mode_request)))
    else $error("mode not taken on idle bus");
  a_reserved_kept: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_rsv_write |=> $stable(mode_request))
    else $error("reserved mode code accepted");
  a_zero_clear: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_zero_clear |=> !flags[0])
    else $error("zero write did not clear flag");
  a_ena_write: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_ena_write |=> (enables == $past(ena_wdata)))
    else $error("enable write lost");
  a_dcmp_invalid: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (sel_dcmp && (data_compare_count > DCMP_MAX)) |-> (rdata[4:0] == 5'h00))
    else $error("invalid compare count shown");
  a_interrupt_code_none: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (buf_pending == 16'h0000 && flags[6:5] == 2'h0 && flags[3:2] == 2'h0) |-> (interrupt_code == INTERRUPT_CODE_NONE))
    else $error("code given with nothing pending");
  a_buf_code: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (buf_pending[8] && buf_pending[7:0] == 8'h00) |-> (interrupt_code == 7'h08))
    else $error("receive-only buffer code wrong");
  a_flag_unused: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !flags[4])
    else $error("unused flag bit set");
  a_normal_pins: assert property (@(posedge sys_clk) disable iff (sys_rst)
    m_normal |-> (tx_pin_enable && rx_pin_enable && (bus_transmit_pin == engine_tx)))
    else $error("normal mode pins wrong");
  a_lall_ignore: assert property (@(posedge sys_clk) disable iff (sys_rst)
    m_lall |-> (ignore_errors && rx_pin_enable))
    else $error("listen-all mode not ignoring errors");
  a_halt_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !idle_stop |-> !block_halt)
    else $error("halt without idle-stop");

endmodule
`default_nettype wire

// File: verif/cmsic_node.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------
// other nodes on the shared bus
// ----------------------------
module cmsic_node (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic dominant,
  output logic      bit_tick,
  output logic      bus_receive_pin
);
  logic [1:0] cnt;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 2'h0;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
  // one bit time every four clocks
  assign bit_tick = (cnt == 2'h3);
  // recessive high whenever no node drives the bus
  assign bus_receive_pin = ~dominant;
endmodule
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import cmsic_pkg::*;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, rerr, bit_tick, bus_receive_pin, engine_rx;
  logic        bus_transmit_pin, tx_pin_enable, rx_pin_enable, ack_err_enable;
  logic        err_count_enable, ignore_errors, abort_all_tx, block_halt;
  logic        capture_event, window_select, irq;
  logic        dominant = 1'b0;
  logic        engine_tx = 1'b0;
  logic        aborts_done = 1'b0;
  logic        chip_idle = 1'b0;
  logic        msg_received = 1'b0;
  logic [4:0]  data_compare_count = 5'h11;
  logic [4:0]  filter_hit_number = 5'h1f;
  logic [15:0] buf_pending = 16'h0;
  logic [2:0]  buffer_count_select, e;
  logic [4:0]  fifo_start_buffer;
  logic [5:0]  fifo_write_pointer = 6'h1f;
  logic [5:0]  fifo_next_read = 6'h1e;
  logic [5:0]  error_state = 6'h2a;
  logic [7:0]  flag_set = 8'h00;
  logic [2:0]  md [7] = '{3'h3, 3'h2, 3'h7, 3'h5, 3'h6, 3'h1, 3'h4};
  logic [7:0]  fb [4] = '{8'h20, 8'h40, 8'h04, 8'h08};
  logic [2:0]  cur = 3'h0;
  int          mismatches = 0;
  int          compares = 0;
  int          cyc = 0;
  cmsic_top dut (
    .sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .bit_tick, .bus_receive_pin, .engine_tx, .engine_rx, .bus_transmit_pin,
    .tx_pin_enable, .rx_pin_enable, .ack_err_enable, .err_count_enable, .ignore_errors,
    .abort_all_tx, .aborts_done, .chip_idle, .block_halt, .msg_received, .capture_event,
    .window_select, .data_compare_count, .filter_hit_number, .buf_pending,
    .buffer_count_select, .fifo_start_buffer, .fifo_write_pointer, .fifo_next_read,
    .error_state, .flag_set, .irq
  );
  cmsic_node node (.sys_clk, .sys_rst, .dominant, .bit_tick, .bus_receive_pin);
  always #2.5 sys_clk = ~sys_clk;
  // ----------------------------
  // helpers
  // ----------------------------
  task automatic print_verdict();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic pulse(input logic [7:0] f);
    @(posedge sys_clk);
    flag_set <= f;
    @(posedge sys_clk);
    flag_set <= 8'h00;
  endtask
  // ----------------------------
  // main sequence
  // ----------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(ADDR_MODE_CTRL, 32'h0480);
    wr(ADDR_FIFO_CTRL, 32'hc01f);
    rd(ADDR_FIFO_CTRL, 32'hc01f);
    chk({buffer_count_select, fifo_start_buffer}, 32'hdf);
    pulse(8'hff);
    @(posedge sys_clk);
    chk(irq, 1'b0);
    rd(ADDR_INT_FLAGS, 32'h2aef);
    wr(ADDR_INT_FLAGS, 32'hff);
    rd(ADDR_INT_FLAGS, 32'h2aef);
    wr(ADDR_INT_ENA, 32'h04);
    chk(irq, 1'b1);
    wr(ADDR_INT_FLAGS, 32'hfb);
    chk(irq, 1'b0);
    rd(ADDR_INT_FLAGS, 32'h2aeb);
    wr(ADDR_INT_ENA, 32'hef);
    rd(ADDR_INT_ENA, 32'hef);
    chk(irq, 1'b1);
    wr(ADDR_INT_FLAGS, 32'h0);
    chk(irq, 1'b0);
    rd(ADDR_INT_VEC, 32'h1f40);
    buf_pending <= 16'h8100;
    rd(ADDR_INT_VEC, 32'h1f08);
    buf_pending <= 16'h0080;
    rd(ADDR_INT_VEC, 32'h1f07);
    buf_pending <= 16'h0000;
    for (int i = 0; i < 4; i++) begin
      pulse(fb[i]);
      rd(ADDR_INT_VEC, 32'h1f41 + i);
      wr(ADDR_INT_FLAGS, 32'h0);
    end
    rd(ADDR_DCMP_CNT, 32'h11);
    data_compare_count <= 5'h12;
    rd(ADDR_DCMP_CNT, 32'h0);
    rd(ADDR_FIFO_PTR, 32'h1f1e);
    apb(1'b0, 8'h1c, 32'h0);
    chk(rerr, 1'b1);
    wr(ADDR_MODE_CTRL, 32'h2409);
    rd(ADDR_MODE_CTRL, 32'h2489);
    chk(window_select, 1'b1);
    msg_received <= 1'b1;
    chip_idle <= 1'b1;
    @(posedge sys_clk);
    chk(capture_event, 1'b1);
    chk(block_halt, 1'b1);
    wr(ADDR_MODE_CTRL, 32'h1400);
    chk(capture_event, 1'b0);
    chk(block_halt, 1'b0);
    chk(window_select, 1'b0);
    chk(abort_all_tx, 1'b1);
    rd(ADDR_MODE_CTRL, 32'h1480);
    aborts_done <= 1'b1;
    msg_received <= 1'b0;
    chip_idle <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(abort_all_tx, 1'b0);
    rd(ADDR_MODE_CTRL, 32'h0480);
    dominant <= 1'b1;
    wr(ADDR_MODE_CTRL, 32'h0);
    repeat (36) @(posedge sys_clk);
    rd(ADDR_MODE_CTRL, 32'h0080);
    dominant <= 1'b0;
    repeat (36) @(posedge sys_clk);
    rd(ADDR_MODE_CTRL, 32'h0080);
    repeat (20) @(posedge sys_clk);
    rd(ADDR_MODE_CTRL, 32'h0);
    engine_tx <= 1'b1;
    @(posedge sys_clk);
    chk({tx_pin_enable, rx_pin_enable, bus_transmit_pin}, 32'h7);
    engine_tx <= 1'b0;
    @(posedge sys_clk);
    chk(bus_transmit_pin, 1'b0);
    wr(ADDR_FIFO_CTRL, 32'h0);
    rd(ADDR_FIFO_CTRL, 32'hc01f);
    wr(ADDR_INT_ENA, 32'h0);
    rd(ADDR_INT_ENA, 32'hef);
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_MODE_CTRL, {21'h0, md[i], 8'h00});
      repeat (60) @(posedge sys_clk);
      e = (md[i] == 3'h5 || md[i] == 3'h6) ? cur : md[i];
      cur = e;
      rd(ADDR_MODE_CTRL, {21'h0, e, e, 5'h0});
      chk({ack_err_enable, err_count_enable}, {30'h0, e == 3'h0, e == 3'h0});
      chk(ignore_errors, e == 3'h7);
      if (e == 3'h3) begin
        chk({tx_pin_enable, rx_pin_enable, bus_transmit_pin}, 32'h3);
      end
      if (e == 3'h2) begin
        chk({tx_pin_enable, rx_pin_enable, engine_rx}, 32'h0);
        engine_tx <= 1'b1;
        @(posedge sys_clk);
        chk(engine_rx, 1'b1);
        engine_tx <= 1'b0;
      end
    end
    print_verdict();
  end
endmodule
`default_nettype wire
